// >>> src/cse_pkg.sv
package cse_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_WORK   = 8'h04;
  localparam logic [7:0] OFF_BANK   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_EXEC   = 8'h10;

  // field positions
  localparam int CTRL_TWO_WORD_BIT = 16;
  localparam int STATUS_N_BIT      = 4;
  localparam int STATUS_Z_BIT      = 2;
  localparam int EXEC_BUSY_BIT     = 0;
  localparam int EXEC_SKIP_BIT     = 1;
  localparam int EXEC_ILLEGAL_BIT  = 2;
  localparam int EXEC_REFUSED_BIT  = 3;
  localparam int EXEC_CYC_LSB      = 4;
  localparam int DEST_BIT          = 9;
  localparam int BANK_BIT          = 8;

  // reset values
  localparam logic [15:0] INSTR_RST  = 16'h0000;
  localparam logic [7:0]  WORK_RST   = 8'h00;
  localparam logic [3:0]  BANK_RST   = 4'h0;
  localparam logic [7:0]  STATUS_RST = 8'h00;

  // opcode patterns
  localparam logic [5:0] OPC_COMPL = 6'h07;
  localparam logic [6:0] OPC_CMPEQ = 7'h31;

  // access bank split and its upper bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI    = 4'hf;

  // phase and cycle counts
  localparam logic [1:0] PHASE_LAST   = 2'h3;
  localparam logic [1:0] NOP_ONE_WORD = 2'h1;
  localparam logic [1:0] NOP_TWO_WORD = 2'h2;
  localparam logic [1:0] CYC_BASE     = 2'h1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_Q1   = 6'b000010,
    ST_Q2   = 6'b000100,
    ST_Q3   = 6'b001000,
    ST_Q4   = 6'b010000,
    ST_NOP  = 6'b100000
  } cse_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cse_dm_req_s;
endpackage : cse_pkg

// >>> src/cse_exec.sv
// Overview of operation
// - complement inverts the addressed byte, writes destination, updates N and Z.
// - destination bit 0 sends result to working register, 1 back to memory.
// - bank bit 0 uses access bank; 1 forms address from bank select register.
// - compare subtracts working register unsigned for equality; no store, flags kept.
// - on equality the fetched instruction is discarded, one no-operation cycle added.
// - if discarded instruction is two words, a second no-operation cycle follows.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module cse_exec (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [7:0]           dm_rdata,
  output cse_pkg::cse_dm_req_s      dm_req,
  output logic                      busy,
  output logic                      flush,
  output logic      [3:0]           qphase
);
  import cse_pkg::*;

  // bus side state
  logic              dph_wr_ff;
  logic              nxt_dph_wr;
  logic [7:0]        dph_addr_ff;
  logic [7:0]        nxt_dph_addr;
  logic [31:0]       hrdata_ff;
  logic [31:0]       nxt_hrdata;
  logic              hreadyout_ff;
  logic              hresp_ff;

  // core state
  cse_state_e        state_ff;
  cse_state_e        nxt_state;
  logic [1:0]        phase_ff;
  logic [1:0]        nxt_phase;
  logic [1:0]        nop_left_ff;
  logic [1:0]        nxt_nop_left;
  logic [15:0]       instr_ff;
  logic [15:0]       nxt_instr;
  logic              two_word_ff;
  logic              nxt_two_word;
  logic [7:0]        work_ff;
  logic [7:0]        nxt_work;
  logic [3:0]        bank_ff;
  logic [3:0]        nxt_bank;
  logic [7:0]        status_ff;
  logic [7:0]        nxt_status;
  cse_dm_req_s       dm_ff;
  cse_dm_req_s       nxt_dm;
  logic              flush_ff;
  logic              nxt_flush;
  logic              skip_ff;
  logic              nxt_skip;
  logic              illegal_ff;
  logic              nxt_illegal;
  logic              refused_ff;
  logic              nxt_refused;
  logic [1:0]        cyc_ff;
  logic [1:0]        nxt_cyc;
  logic [3:0]        qph_ff;
  logic [3:0]        nxt_qph;
  logic              busy_ff;
  logic              nxt_busy;

  // decode of the held instruction word
  logic              is_compl;
  logic              is_cmpeq;
  logic [7:0]        result;
  logic [7:0]        diff;

  assign is_compl = (instr_ff[15:10] == OPC_COMPL);
  assign is_cmpeq = (instr_ff[15:9] == OPC_CMPEQ);
  assign result   = ~dm_rdata;
  assign diff     = dm_rdata - work_ff;

  // outputs straight from flops
  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;
  assign dm_req    = dm_ff;
  assign busy      = busy_ff;
  assign flush     = flush_ff;
  assign qphase    = qph_ff;

  // bus address phase capture and read mux
  always_comb begin
    nxt_dph_wr   = 1'b0;
    nxt_dph_addr = dph_addr_ff;
    nxt_hrdata   = 32'h0000_0000;
    if (hsel && htrans[1] && hready) begin
      nxt_dph_wr   = hwrite;
      nxt_dph_addr = haddr[7:0];
      if (!hwrite) begin
        if (haddr[7:0] == OFF_CTRL) begin
          nxt_hrdata[15:0]              = instr_ff;
          nxt_hrdata[CTRL_TWO_WORD_BIT] = two_word_ff;
        end else if (haddr[7:0] == OFF_WORK) begin
          nxt_hrdata[7:0] = work_ff;
        end else if (haddr[7:0] == OFF_BANK) begin
          nxt_hrdata[3:0] = bank_ff;
        end else if (haddr[7:0] == OFF_STATUS) begin
          nxt_hrdata[7:0] = status_ff;
        end else if (haddr[7:0] == OFF_EXEC) begin
          nxt_hrdata[EXEC_BUSY_BIT]                   = busy_ff;
          nxt_hrdata[EXEC_SKIP_BIT]                   = skip_ff;
          nxt_hrdata[EXEC_ILLEGAL_BIT]                = illegal_ff;
          nxt_hrdata[EXEC_REFUSED_BIT]                = refused_ff;
          nxt_hrdata[EXEC_CYC_LSB+1:EXEC_CYC_LSB]     = cyc_ff;
        end
      end
    end
  end

  // bus registers; zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff    <= 1'b0;
      dph_addr_ff  <= 8'h00;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      dph_wr_ff    <= nxt_dph_wr;
      dph_addr_ff  <= nxt_dph_addr;
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // core sequencer, register writes and datapath
  always_comb begin
    nxt_state    = state_ff;
    nxt_phase    = phase_ff;
    nxt_nop_left = nop_left_ff;
    nxt_instr    = instr_ff;
    nxt_two_word = two_word_ff;
    nxt_work     = work_ff;
    nxt_bank     = bank_ff;
    nxt_status   = status_ff;
    nxt_dm       = dm_ff;
    nxt_dm.we    = 1'b0;
    nxt_dm.re    = 1'b0;
    nxt_flush    = 1'b0;
    nxt_skip     = skip_ff;
    nxt_illegal  = illegal_ff;
    nxt_refused  = refused_ff;
    nxt_cyc      = cyc_ff;
    nxt_qph      = qph_ff;
    // software writes; writes to ctrl, work, bank and status are dropped and set refused while an instruction runs
    if (dph_wr_ff) begin
      if (dph_addr_ff == OFF_EXEC && hwdata[EXEC_REFUSED_BIT]) begin
        nxt_refused = 1'b0;
      end
      if (dph_addr_ff == OFF_CTRL || dph_addr_ff == OFF_WORK ||
          dph_addr_ff == OFF_BANK || dph_addr_ff == OFF_STATUS) begin
        if (state_ff != ST_IDLE) begin
          nxt_refused = 1'b1;
        end else if (dph_addr_ff == OFF_CTRL) begin
          nxt_instr    = hwdata[15:0];
          nxt_two_word = hwdata[CTRL_TWO_WORD_BIT];
          nxt_state    = ST_Q1;
          nxt_skip     = 1'b0;
          nxt_illegal  = 1'b0;
          nxt_cyc      = CYC_BASE;
          nxt_qph      = 4'h1;
        end else if (dph_addr_ff == OFF_WORK) begin
          nxt_work = hwdata[7:0];
        end else if (dph_addr_ff == OFF_BANK) begin
          nxt_bank = hwdata[3:0];
        end else begin
          nxt_status = hwdata[7:0];
        end
      end
    end
    case (state_ff)
      ST_Q1: begin
        nxt_qph = 4'h2;
        if (is_compl || is_cmpeq) begin
          nxt_state = ST_Q2;
          nxt_dm.re = 1'b1;
          if (instr_ff[BANK_BIT]) begin
            nxt_dm.addr = {bank_ff, instr_ff[7:0]};
          end else if (instr_ff[7:0] < ACCESS_SPLIT) begin
            nxt_dm.addr = {4'h0, instr_ff[7:0]};
          end else begin
            nxt_dm.addr = {ACCESS_HI, instr_ff[7:0]};
          end
        end else begin
          nxt_illegal = 1'b1;
          nxt_state   = ST_IDLE;
          nxt_qph     = 4'h0;
        end
      end
      ST_Q2: begin
        nxt_state = ST_Q3;
        nxt_qph   = 4'h4;
      end
      ST_Q3: begin
        nxt_state = ST_Q4;
        nxt_qph   = 4'h8;
        if (is_compl) begin
          nxt_status[STATUS_N_BIT] = result[7];
          nxt_status[STATUS_Z_BIT] = (result == 8'h00);
          if (instr_ff[DEST_BIT]) begin
            nxt_dm.wdata = result;
            nxt_dm.we    = 1'b1;
          end else begin
            nxt_work = result;
          end
        end else if (diff == 8'h00) begin
          nxt_skip  = 1'b1;
          nxt_flush = 1'b1;
          if (two_word_ff) begin
            nxt_nop_left = NOP_TWO_WORD;
          end else begin
            nxt_nop_left = NOP_ONE_WORD;
          end
          nxt_cyc = CYC_BASE + nxt_nop_left;
        end
      end
      ST_Q4: begin
        if (nop_left_ff != 2'h0) begin
          nxt_state = ST_NOP;
          nxt_phase = 2'h0;
          nxt_qph   = 4'h1;
        end else begin
          nxt_state = ST_IDLE;
          nxt_qph   = 4'h0;
        end
      end
      ST_NOP: begin
        nxt_phase = phase_ff + 2'h1;
        nxt_qph   = {qph_ff[2:0], qph_ff[3]};
        if (phase_ff == PHASE_LAST) begin
          nxt_nop_left = nop_left_ff - 2'h1;
          if (nop_left_ff == 2'h1) begin
            nxt_state = ST_IDLE;
            nxt_qph   = 4'h0;
          end
        end
      end
      default: begin
      end
    endcase
    nxt_busy = (nxt_state != ST_IDLE);
  end

  // core registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff    <= ST_IDLE;
      phase_ff    <= 2'h0;
      nop_left_ff <= 2'h0;
      instr_ff    <= INSTR_RST;
      two_word_ff <= 1'b0;
      work_ff     <= WORK_RST;
      bank_ff     <= BANK_RST;
      status_ff   <= STATUS_RST;
      dm_ff       <= '0;
      flush_ff    <= 1'b0;
      skip_ff     <= 1'b0;
      illegal_ff  <= 1'b0;
      refused_ff  <= 1'b0;
      cyc_ff      <= 2'h0;
      qph_ff      <= 4'h0;
      busy_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      phase_ff    <= nxt_phase;
      nop_left_ff <= nxt_nop_left;
      instr_ff    <= nxt_instr;
      two_word_ff <= nxt_two_word;
      work_ff     <= nxt_work;
      bank_ff     <= nxt_bank;
      status_ff   <= nxt_status;
      dm_ff       <= nxt_dm;
      flush_ff    <= nxt_flush;
      skip_ff     <= nxt_skip;
      illegal_ff  <= nxt_illegal;
      refused_ff  <= nxt_refused;
      cyc_ff      <= nxt_cyc;
      qph_ff      <= nxt_qph;
      busy_ff     <= nxt_busy;
    end
  end
endmodule : cse_exec

// >>> tb/cse_exec_monitor.sv
`timescale 1ns/1ps
module cse_exec_monitor
  import cse_pkg::*;
(
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic [7:0]           dm_rdata,
  input wire cse_pkg::cse_dm_req_s dm_req,
  input wire logic                 busy,
  input wire logic                 flush,
  input wire logic [3:0]           qphase
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // operand fetch and write-back slots, phase order, flush and empty cycle checks
  chk_read_q2: assert property (dm_req.re |-> qphase == 4'h2)
    else $error("operand read outside q2");
  chk_write_q4: assert property (dm_req.we |-> qphase == 4'h8 && dm_req.addr == $past(dm_req.addr, 2))
    else $error("write slot or address wrong");
  chk_write_inverse: assert property (dm_req.we |-> dm_req.wdata == ~$past(dm_rdata))
    else $error("written byte not inverted operand");
  chk_phase_walk: assert property (qphase == 4'h2 |=> qphase == 4'h4 ##1 qphase == 4'h8)
    else $error("phase order broken");
  chk_flush_quiet: assert property (flush |-> qphase == 4'h8 && !dm_req.we)
    else $error("flush off q4 or with a store");
  chk_flush_nop: assert property (flush |=> busy && qphase == 4'h1)
    else $error("no empty cycle after flush");
  chk_nop_length: assert property (flush |=> busy [*4] ##1 (!busy or busy [*4] ##1 !busy))
    else $error("empty cycle count wrong");
  chk_busy_phase: assert property ($onehot0(qphase) && busy == (qphase != 4'h0))
    else $error("busy and phase disagree");

  // main scenarios
  cover property (flush);
  cover property (dm_req.we);
  cover property (flush ##5 busy);
  cover property (busy && qphase == 4'h1 ##1 !busy);
endmodule : cse_exec_monitor

bind cse_exec cse_exec_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .dm_rdata(dm_rdata), .dm_req(dm_req),
  .busy(busy), .flush(flush), .qphase(qphase)
);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cse_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy, flush;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  qphase;
  logic [7:0]  dm_rdata;
  logic [7:0]  mem [0:4095];
  cse_dm_req_s dm_req;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;

  cse_exec DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dm_rdata(dm_rdata),
    .dm_req(dm_req), .busy(busy), .flush(flush), .qphase(qphase)
  );

  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // registered data memory, junk when not read, plus cycle limit
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (!hresetn) dm_rdata <= 8'h00;
    else if (dm_req.re) dm_rdata <= mem[dm_req.addr];
    else dm_rdata <= ~dm_rdata;
    if (dm_req.we) mem[dm_req.addr] <= dm_req.wdata;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one single transfer, read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // start an instruction, count busy cycles and flush pulses
  task automatic run(input logic [16:0] ctrl, output int n, output int fl);
    ahb(1'b1, OFF_CTRL, {15'h0, ctrl});
    n  = 0;
    fl = 0;
    do begin
      @(posedge hclk);
      n++;
      if (flush === 1'b1) fl++;
    end while (busy === 1'b1 && n < 60);
  endtask : run

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    int          n, fl, cy;
    logic [11:0] ad;
    logic [7:0]  f, w, s, b, r;
    logic [3:0]  bk;
    logic        d, a, tw, op, sk;
    {hresetn, hsel, htrans, hwrite, hsize, haddr, hwdata} = 72'h0;
    hsel  = 1'b1;
    hsize = 3'h2;
    seed  = 32'h70f3d753;
    for (int k = 0; k < 4096; k++) begin
      seed   = lfsr(seed);
      mem[k] = seed[7:0];
    end
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values
    for (int k = 0; k < 5; k++) begin
      ahb(1'b0, 8'(k * 4), 32'h0);
      check(rd, 32'h0);
    end
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      {s, w, bk, tw, a, d, f} = {seed[31:16], seed[15:12], seed[10:8], seed[7:0]};
      op = i[0];
      ad = a ? {bk, f} : (f < 8'h80 ? {4'h0, f} : {4'hf, f});
      b  = mem[ad];
      if (op && i[1]) w = b;
      ahb(1'b1, OFF_BANK, {28'h0, bk});
      ahb(1'b1, OFF_WORK, {24'h0, w});
      ahb(1'b1, OFF_STATUS, {24'h0, s});
      run({tw, op ? {OPC_CMPEQ, a, f} : {OPC_COMPL, d, a, f}}, n, fl);
      sk = op && b == w;
      cy = sk ? (tw ? 3 : 2) : 1;
      if (!op) begin
        r = ~b;
        if (d) b = r;
        else w = r;
        s[4] = r[7];
        s[2] = r == 8'h0;
      end
      check(n - 1, 4 * cy);
      check(fl, {31'h0, sk});
      check({24'h0, mem[ad]}, {24'h0, b});
      ahb(1'b0, OFF_WORK, 32'h0);
      check(rd, {24'h0, w});
      ahb(1'b0, OFF_STATUS, 32'h0);
      check(rd, {24'h0, s});
      ahb(1'b0, OFF_EXEC, 32'h0);
      check(rd, {26'h0, 2'(cy), 2'b00, sk, 1'b0});
    end
    // write while busy is dropped, then cleared, then unmapped place
    ahb(1'b1, OFF_WORK, {24'h0, mem[12'h07f]});
    ahb(1'b1, OFF_CTRL, {16'h1, OPC_CMPEQ, 1'b0, 8'h7f});
    ahb(1'b1, OFF_WORK, {24'h0, ~mem[12'h07f]});
    repeat (16) @(posedge hclk);
    ahb(1'b0, OFF_EXEC, 32'h0);
    check(rd, 32'h3a);
    ahb(1'b0, OFF_WORK, 32'h0);
    check(rd, {24'h0, mem[12'h07f]});
    ahb(1'b1, OFF_EXEC, 32'h8);
    ahb(1'b0, OFF_EXEC, 32'h0);
    check(rd, 32'h32);
    ahb(1'b1, 8'h40, 32'hffffffff);
    ahb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    // unknown opcode: illegal flag, back to idle after one phase
    run(17'h0_0000, n, fl);
    check(n - 1, 32'h1);
    ahb(1'b0, OFF_EXEC, 32'h0);
    check(rd, 32'h14);
    // write with select low is ignored
    hsel <= 1'b0;
    ahb(1'b1, OFF_WORK, 32'h5a);
    hsel <= 1'b1;
    ahb(1'b0, OFF_WORK, 32'h0);
    check(rd, {24'h0, mem[12'h07f]});
    print_verdict();
  end
endmodule : tb_top
